// ### common/stp_pkg.sv
`default_nettype none
package stp_pkg;
	// Register indices; the byte address on the bus is four times the index.
	localparam logic [9:0] IDX_CTRL = 10'h0C8;
	localparam logic [9:0] IDX_RLL  = 10'h0CA;
	localparam logic [9:0] IDX_RLH  = 10'h0CB;
	localparam logic [9:0] IDX_CNTL = 10'h0CC;
	localparam logic [9:0] IDX_CNTH = 10'h0CD;
	localparam logic [9:0] IDX_CSEL = 10'h0CE;
	localparam logic [9:0] IDX_IEN  = 10'h0CF;
	localparam logic [9:0] IDX_STAT = 10'h0D0;
	localparam logic [9:0] IDX_MASK = 10'h0D1;
	// Field positions in the clock select, enable and interrupt registers.
	localparam int unsigned CSEL_LOW  = 0;
	localparam int unsigned CSEL_HIGH = 1;
	localparam int unsigned IEN_TIMER = 0;
	localparam int unsigned ST_HIGH   = 0;
	localparam int unsigned ST_LOW    = 1;
	// Values after reset.
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] RLD_RST  = 8'h00;
	localparam logic [7:0] CNT_RST  = 8'h00;
	localparam logic [1:0] CSEL_RST = 2'h0;
	localparam logic [1:0] STAT_RST = 2'h0;
	localparam logic [1:0] MASK_RST = 2'h0;
	// Prescaler terminal counts: divide by twelve and by eight.
	localparam logic [3:0] DIV12_MAX = 4'hB;
	localparam logic [2:0] DIV8_MAX  = 3'h7;
	// AXI responses.
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Control register layout, bit 7 first.
	typedef struct packed {
		logic hflag;
		logic lflag;
		logic lowen;
		logic rsv4;
		logic split;
		logic run;
		logic rsv1;
		logic xclk;
	} stp_ctrl_type;
endpackage
`default_nettype wire

// ### logic/stp_timer.sv
// Overview of operation
// - Count is two separately accessible byte registers.
// - Split bit clear gives one 16-bit timer.
// - Split bit set gives two reloading 8-bit timers.
// - Sources: system clock, divided twelve, external/8.
// - External divided clock synchronised before use.
// - 16-bit rollover loads both reload bytes.
// - 16-bit rollover sets high overflow flag.
// - Enabled interrupt on every 16-bit overflow.
// - Low-byte enable adds low rollover interrupt.
// - 16-bit mode: run bit zero stops, one counts.
// - Reload low byte register, read/write, resets zero.
// - Split mode: run gates high byte only.
// - Per-byte select: system clock else external select.
// - Split flags set on rollover, cleared by software.
//
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module stp_timer (
	// Clock and reset.
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// External oscillator input, asynchronous to aclk.
	input  wire logic        external_osc_clk,
	// AXI4-Lite write address and data.
	input  wire logic [11:0] awaddr,
	input  wire logic [2:0]  awprot,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	// AXI4-Lite write response.
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	// AXI4-Lite read.
	input  wire logic [11:0] araddr,
	input  wire logic [2:0]  arprot,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	// Interrupt request, level.
	output logic             irq
);
	stp_pkg::stp_ctrl_type ctrl_ff;
	stp_pkg::stp_ctrl_type nxt_ctrl;
	logic [7:0]  rll_ff;
	logic [7:0]  rlh_ff;
	logic [7:0]  cl_ff;
	logic [7:0]  ch_ff;
	logic [7:0]  nxt_cl;
	logic [7:0]  nxt_ch;
	logic [1:0]  csel_ff;
	logic        ien_ff;
	logic [1:0]  stat_ff;
	logic [1:0]  mask_ff;
	logic        irq_ff;
	logic [3:0]  d12_ff;
	logic [2:0]  x8_ff;
	logic        x_s1_ff;
	logic        x_s2_ff;
	logic        x_s3_ff;
	logic        x_edge;
	logic        t12;
	logic        t_ext;
	logic        t_sel;
	logic        tick_l;
	logic        tick_h;
	logic        ev_h;
	logic        ev_l;
	logic        awready_ff;
	logic        wready_ff;
	logic        bvalid_ff;
	logic [1:0]  bresp_ff;
	logic        arready_ff;
	logic        rvalid_ff;
	logic [31:0] rdata_ff;
	logic [1:0]  rresp_ff;
	logic        aw_got_ff;
	logic        w_got_ff;
	logic [9:0]  wa_ff;
	logic [7:0]  wd_ff;
	logic        ws_ff;
	logic        do_wr;
	logic        wr_map;
	logic        ar_hs;
	logic [9:0]  ra_idx;
	logic [7:0]  rd_val;
	logic        rd_map;
	logic        wr_ctrl;
	logic        wr_cl;
	logic        wr_ch;

	// Prescaler for the system clock divided by twelve; it runs free so both bytes share one phase.
	always_ff @(posedge aclk) begin
		if (!aresetn || t12) begin
			d12_ff <= 4'h0;
		end else begin
			d12_ff <= d12_ff + 4'h1;
		end
	end
	assign t12 = (d12_ff == stp_pkg::DIV12_MAX);

	// Three-stage synchroniser; an edge counts when the second stage is high and the third is still low.
	// The source must be no faster than half the aclk rate or edges are lost.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			x_s1_ff <= 1'b0;
			x_s2_ff <= 1'b0;
			x_s3_ff <= 1'b0;
		end else begin
			x_s1_ff <= external_osc_clk;
			x_s2_ff <= x_s1_ff;
			x_s3_ff <= x_s2_ff;
		end
	end
	assign x_edge = x_s2_ff & ~x_s3_ff;

	// Divide the synchronised external edges by eight.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			x8_ff <= 3'h0;
		end else if (x_edge) begin
			x8_ff <= x8_ff + 3'h1;
		end
	end
	assign t_ext = x_edge & (x8_ff == stp_pkg::DIV8_MAX);

	// Per-byte source: system clock when selected, else divided clock picked by the external select.
	assign t_sel  = ctrl_ff.xclk ? t_ext : t12;
	assign tick_l = csel_ff[stp_pkg::CSEL_LOW] | t_sel;
	assign tick_h = csel_ff[stp_pkg::CSEL_HIGH] | t_sel;

	// Software write strobes for the registers that the count logic also drives.
	assign wr_ctrl = do_wr & ws_ff & (wa_ff == stp_pkg::IDX_CTRL);
	assign wr_cl   = do_wr & ws_ff & (wa_ff == stp_pkg::IDX_CNTL);
	assign wr_ch   = do_wr & ws_ff & (wa_ff == stp_pkg::IDX_CNTH);

	// Count next state; a software write to a count byte wins over counting that byte.
	always_comb begin
		nxt_cl = cl_ff;
		nxt_ch = ch_ff;
		ev_h   = 1'b0;
		ev_l   = 1'b0;
		if (!ctrl_ff.split) begin
			if (ctrl_ff.run && tick_l) begin
				ev_l = (cl_ff == 8'hFF);
				if ({ch_ff, cl_ff} == 16'hFFFF) begin
					{nxt_ch, nxt_cl} = {rlh_ff, rll_ff};
					ev_h = 1'b1;
				end else begin
					{nxt_ch, nxt_cl} = {ch_ff, cl_ff} + 16'h0001;
				end
			end
		end else begin
			// The low byte runs regardless of the run bit.
			if (tick_l) begin
				if (cl_ff == 8'hFF) begin
					nxt_cl = rll_ff;
					ev_l = 1'b1;
				end else begin
					nxt_cl = cl_ff + 8'h01;
				end
			end
			if (ctrl_ff.run && tick_h) begin
				if (ch_ff == 8'hFF) begin
					nxt_ch = rlh_ff;
					ev_h = 1'b1;
				end else begin
					nxt_ch = ch_ff + 8'h01;
				end
			end
		end
		if (wr_cl) begin
			nxt_cl = wd_ff;
		end
		if (wr_ch) begin
			nxt_ch = wd_ff;
		end
	end

	// Count bytes.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cl_ff <= stp_pkg::CNT_RST;
			ch_ff <= stp_pkg::CNT_RST;
		end else begin
			cl_ff <= nxt_cl;
			ch_ff <= nxt_ch;
		end
	end

	// Control write; hardware sets of the flags win over a software clear in the same cycle.
	always_comb begin
		nxt_ctrl = ctrl_ff;
		if (wr_ctrl) begin
			nxt_ctrl = stp_pkg::stp_ctrl_type'(wd_ff);
		end
		nxt_ctrl.rsv4  = 1'b0;
		nxt_ctrl.rsv1  = 1'b0;
		nxt_ctrl.hflag = nxt_ctrl.hflag | ev_h;
		nxt_ctrl.lflag = nxt_ctrl.lflag | ev_l;
	end

	// Control register.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_ff <= stp_pkg::stp_ctrl_type'(stp_pkg::CTRL_RST);
		end else begin
			ctrl_ff <= nxt_ctrl;
		end
	end

	// Reload, clock select, enable and mask registers.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rll_ff  <= stp_pkg::RLD_RST;
			rlh_ff  <= stp_pkg::RLD_RST;
			csel_ff <= stp_pkg::CSEL_RST;
			ien_ff  <= 1'b0;
			mask_ff <= stp_pkg::MASK_RST;
		end else if (do_wr && ws_ff) begin
			if (wa_ff == stp_pkg::IDX_RLL) begin
				rll_ff <= wd_ff;
			end
			if (wa_ff == stp_pkg::IDX_RLH) begin
				rlh_ff <= wd_ff;
			end
			if (wa_ff == stp_pkg::IDX_CSEL) begin
				csel_ff <= wd_ff[1:0];
			end
			if (wa_ff == stp_pkg::IDX_IEN) begin
				ien_ff <= wd_ff[stp_pkg::IEN_TIMER];
			end
			if (wa_ff == stp_pkg::IDX_MASK) begin
				mask_ff <= wd_ff[1:0];
			end
		end
	end

	// Sticky event status, cleared by reading it; a new event in the clearing cycle survives.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stat_ff <= stp_pkg::STAT_RST;
		end else begin
			stat_ff <= ((ar_hs && ra_idx == stp_pkg::IDX_STAT) ? 2'h0 : stat_ff) | {ev_l, ev_h};
		end
	end

	// Interrupt: low events only count while the low-byte enable is set.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= ien_ff & |(stat_ff & mask_ff & {ctrl_ff.lowen, 1'b1});
		end
	end

	// Write channel capture; address and data may arrive in either order.
	assign do_wr = aw_got_ff & w_got_ff & ~bvalid_ff;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_ff <= 1'b1;
			wready_ff  <= 1'b1;
			aw_got_ff  <= 1'b0;
			w_got_ff   <= 1'b0;
			wa_ff      <= 10'h000;
			wd_ff      <= 8'h00;
			ws_ff      <= 1'b0;
			bvalid_ff  <= 1'b0;
			bresp_ff   <= stp_pkg::RESP_OKAY;
		end else begin
			if (awvalid && awready_ff) begin
				awready_ff <= 1'b0;
				aw_got_ff  <= 1'b1;
				wa_ff      <= awaddr[11:2];
			end
			if (wvalid && wready_ff) begin
				wready_ff <= 1'b0;
				w_got_ff  <= 1'b1;
				wd_ff     <= wdata[7:0];
				ws_ff     <= wstrb[0];
			end
			if (do_wr) begin
				aw_got_ff <= 1'b0;
				w_got_ff  <= 1'b0;
				bvalid_ff <= 1'b1;
				bresp_ff  <= wr_map ? stp_pkg::RESP_OKAY : stp_pkg::RESP_SLVERR;
			end
			if (bvalid_ff && bready) begin
				bvalid_ff  <= 1'b0;
				awready_ff <= 1'b1;
				wready_ff  <= 1'b1;
			end
		end
	end

	// Address decode for writes; the status register is read-only but accepts writes silently.
	always_comb begin
		unique case (wa_ff)
			stp_pkg::IDX_CTRL, stp_pkg::IDX_RLL, stp_pkg::IDX_RLH, stp_pkg::IDX_CNTL,
			stp_pkg::IDX_CNTH, stp_pkg::IDX_CSEL, stp_pkg::IDX_IEN, stp_pkg::IDX_STAT,
			stp_pkg::IDX_MASK: wr_map = 1'b1;
			default: wr_map = 1'b0;
		endcase
	end

	// Read decode; narrow registers sit in the low bits.
	assign ra_idx = araddr[11:2];
	assign ar_hs  = arvalid & arready_ff;
	always_comb begin
		rd_map = 1'b1;
		unique case (ra_idx)
			stp_pkg::IDX_CTRL: rd_val = ctrl_ff;
			stp_pkg::IDX_RLL:  rd_val = rll_ff;
			stp_pkg::IDX_RLH:  rd_val = rlh_ff;
			stp_pkg::IDX_CNTL: rd_val = cl_ff;
			stp_pkg::IDX_CNTH: rd_val = ch_ff;
			stp_pkg::IDX_CSEL: rd_val = {6'h00, csel_ff};
			stp_pkg::IDX_IEN:  rd_val = {7'h00, ien_ff};
			stp_pkg::IDX_STAT: rd_val = {6'h00, stat_ff};
			stp_pkg::IDX_MASK: rd_val = {6'h00, mask_ff};
			default: begin
				rd_val = 8'h00;
				rd_map = 1'b0;
			end
		endcase
	end

	// Read channel: data is captured with the address, so the answer comes one cycle later.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_ff <= 1'b1;
			rvalid_ff  <= 1'b0;
			rdata_ff   <= 32'h00000000;
			rresp_ff   <= stp_pkg::RESP_OKAY;
		end else if (ar_hs) begin
			arready_ff <= 1'b0;
			rvalid_ff  <= 1'b1;
			rdata_ff   <= {24'h000000, rd_val};
			rresp_ff   <= rd_map ? stp_pkg::RESP_OKAY : stp_pkg::RESP_SLVERR;
		end else if (rvalid_ff && rready) begin
			arready_ff <= 1'b1;
			rvalid_ff  <= 1'b0;
		end
	end

	// Outputs come straight from flip-flops.
	assign awready = awready_ff;
	assign wready  = wready_ff;
	assign bvalid  = bvalid_ff;
	assign bresp   = bresp_ff;
	assign arready = arready_ff;
	assign rvalid  = rvalid_ff;
	assign rdata   = rdata_ff;
	assign rresp   = rresp_ff;
	assign irq     = irq_ff;

	// Checks on counting, flags and interrupt.
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	AST_RELOAD16: assert property (!ctrl_ff.split && ctrl_ff.run && tick_l && {ch_ff, cl_ff} == 16'hFFFF
		&& !wr_cl && !wr_ch |=> {ch_ff, cl_ff} == $past({rlh_ff, rll_ff}))
		else $error("16-bit rollover did not reload");
	AST_HFLAG16: assert property (!ctrl_ff.split && ctrl_ff.run && tick_l && {ch_ff, cl_ff} == 16'hFFFF
		|=> ctrl_ff.hflag && stat_ff[stp_pkg::ST_HIGH])
		else $error("16-bit rollover did not set flag");
	AST_STOP16: assert property (!ctrl_ff.split && !ctrl_ff.run && !wr_cl && !wr_ch
		|=> $stable({ch_ff, cl_ff}))
		else $error("stopped timer changed");
	AST_SPLITLOW: assert property (ctrl_ff.split && tick_l && cl_ff == 8'hFF && !wr_cl
		|=> cl_ff == $past(rll_ff) && ctrl_ff.lflag)
		else $error("low byte did not reload in split mode");
	AST_SPLITRUN: assert property (ctrl_ff.split && !ctrl_ff.run && !wr_ch |=> $stable(ch_ff))
		else $error("high byte moved while stopped");
	AST_STICKY: assert property (ctrl_ff.hflag && !wr_ctrl |=> ctrl_ff.hflag)
		else $error("overflow flag cleared by hardware");
	AST_UNUSED: assert property (ctrl_ff.rsv4 == 1'b0 && ctrl_ff.rsv1 == 1'b0)
		else $error("unused control bit set");
	AST_IRQHIGH: assert property (ien_ff && stat_ff[stp_pkg::ST_HIGH] && mask_ff[stp_pkg::ST_HIGH] |=> irq)
		else $error("overflow interrupt missing");
	AST_IRQLOW: assert property (!ien_ff || (!stat_ff[stp_pkg::ST_HIGH] && !ctrl_ff.lowen) |=> !irq)
		else $error("interrupt without enabled source");
	AST_DIV12: assert property (t12 |=> !t12 [*8] ##1 !t12 ##1 !t12 ##1 !t12 ##1 t12)
		else $error("divide by twelve period wrong");
	AST_EXT8: assert property (t_ext |=> !t_ext [*7])
		else $error("external divide too fast");

	COV_RELOAD16: cover property (!ctrl_ff.split && ev_h);
	COV_SPLITLOW: cover property (ctrl_ff.split && ev_l);
	COV_IRQ: cover property (!irq ##1 irq);
endmodule
`default_nettype wire

// ### test/stp_timer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module stp_timer_tb;
	// Bench-driven inputs and observed outputs.
	logic             aclk, aresetn, ext_osc;
	logic [11:0]      awaddr, araddr;
	logic             awvalid, wvalid, bready, arvalid, rready;
	logic [31:0]      wdata;
	logic [3:0]       wstrb;
	wire logic        awready, wready, bvalid, arready, rvalid, irq;
	wire logic [1:0]  bresp, rresp;
	wire logic [31:0] rdata;
	int               num_errors, checks;
	logic [31:0]      rd;
	logic [1:0]       rs;

	stp_timer dut (.aclk(aclk), .aresetn(aresetn), .external_osc_clk(ext_osc), .awaddr(awaddr), .awprot(3'h0),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .irq(irq));

	// Free-running 125 MHz clock.
	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end

	// Compares one value and counts it.
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Prints the counts and the verdict, then stops.
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask

	// One write; ready is sampled a moment after the edge so the decision holds at the next edge.
	task automatic wr(input logic [9:0] idx, input logic [7:0] d);
		logic a, w, ta, tw, tb;
		a = 1'b1;
		w = 1'b1;
		awaddr <= {idx, 2'b00};
		wdata <= {24'h000000, d};
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			#1;
			ta = awready;
			tw = wready;
			@(posedge aclk);
			if (a && ta) begin
				awvalid <= 1'b0;
				a = 1'b0;
			end
			if (w && tw) begin
				wvalid <= 1'b0;
				w = 1'b0;
			end
		end while (a || w);
		do begin
			#1;
			tb = bvalid;
			rs = bresp;
			@(posedge aclk);
		end while (!tb);
	endtask

	// One read; data and response are taken at the edge where rvalid is seen.
	task automatic rdr(input logic [9:0] idx);
		logic ta, tr;
		araddr <= {idx, 2'b00};
		arvalid <= 1'b1;
		do begin
			#1;
			ta = arready;
			@(posedge aclk);
		end while (!ta);
		arvalid <= 1'b0;
		do begin
			#1;
			tr = rvalid;
			rd = rdata;
			rs = rresp;
			@(posedge aclk);
		end while (!tr);
	endtask

	// Reset values, read-only control bits and an unmapped place.
	task automatic t_regs();
		rdr(stp_pkg::IDX_CTRL);
		check(rd, 32'h00000000);
		rdr(stp_pkg::IDX_RLL);
		check(rd, 32'h00000000);
		wr(stp_pkg::IDX_RLL, 8'hA5);
		rdr(stp_pkg::IDX_RLL);
		check(rd, 32'h000000A5);
		wr(stp_pkg::IDX_CTRL, 8'h12);
		rdr(stp_pkg::IDX_CTRL);
		check(rd, 32'h00000000);
		rdr(10'h0C9);
		check(rd, 32'h00000000);
		check(rs, stp_pkg::RESP_SLVERR);
		wr(10'h0C9, 8'h55);
		check(rs, stp_pkg::RESP_SLVERR);
		$display("test registers done");
	endtask

	// Sixteen-bit rollover, reload, flags and interrupt.
	task automatic t_wide();
		logic [7:0] hold;
		wr(stp_pkg::IDX_CSEL, 8'h01);
		wr(stp_pkg::IDX_RLH, 8'h12);
		wr(stp_pkg::IDX_RLL, 8'h34);
		wr(stp_pkg::IDX_CNTL, 8'hF0);
		wr(stp_pkg::IDX_CNTH, 8'hFF);
		wr(stp_pkg::IDX_IEN, 8'h01);
		wr(stp_pkg::IDX_MASK, 8'h01);
		check(irq, 1'b0);
		wr(stp_pkg::IDX_CTRL, 8'h04);
		cyc(40);
		check(irq, 1'b1);
		rdr(stp_pkg::IDX_CTRL);
		check(rd, 32'h000000C4);
		wr(stp_pkg::IDX_CTRL, 8'h00);
		rdr(stp_pkg::IDX_CNTH);
		check(rd, 32'h00000012);
		rdr(stp_pkg::IDX_CNTL);
		check(rd >= 32'h34 && rd < 32'hA0, 1'b1);
		rdr(stp_pkg::IDX_STAT);
		check(rd, 32'h00000003);
		cyc(3);
		check(irq, 1'b0);
		rdr(stp_pkg::IDX_CNTL);
		hold = rd[7:0];
		cyc(30);
		rdr(stp_pkg::IDX_CNTL);
		check(rd, {24'h000000, hold});
		$display("test wide mode done");
	endtask

	// Divided sources: twelve system cycles, and eight external edges, per step.
	task automatic t_src();
		wr(stp_pkg::IDX_CSEL, 8'h00);
		wr(stp_pkg::IDX_CNTL, 8'h00);
		wr(stp_pkg::IDX_CNTH, 8'h00);
		wr(stp_pkg::IDX_CTRL, 8'h04);
		cyc(120);
		wr(stp_pkg::IDX_CTRL, 8'h00);
		rdr(stp_pkg::IDX_CNTL);
		check(rd >= 32'd9 && rd <= 32'd11, 1'b1);
		wr(stp_pkg::IDX_CNTL, 8'h00);
		wr(stp_pkg::IDX_CTRL, 8'h05);
		// The external clock runs at a quarter of the system clock, never faster.
		repeat (160) begin
			cyc(2);
			ext_osc <= ~ext_osc;
		end
		cyc(10);
		wr(stp_pkg::IDX_CTRL, 8'h00);
		rdr(stp_pkg::IDX_CNTL);
		check(rd >= 32'd9 && rd <= 32'd11, 1'b1);
		$display("test clock sources done");
	endtask

	// Split mode: low byte free-running, high byte gated, low interrupt enable.
	task automatic t_split();
		wr(stp_pkg::IDX_CSEL, 8'h03);
		wr(stp_pkg::IDX_RLL, 8'hF0);
		wr(stp_pkg::IDX_RLH, 8'h55);
		wr(stp_pkg::IDX_CNTH, 8'h77);
		wr(stp_pkg::IDX_CNTL, 8'hFE);
		wr(stp_pkg::IDX_CTRL, 8'h08);
		cyc(20);
		rdr(stp_pkg::IDX_CNTH);
		check(rd, 32'h00000077);
		rdr(stp_pkg::IDX_CNTL);
		check(rd[7:4], 4'hF);
		rdr(stp_pkg::IDX_CTRL);
		check(rd, 32'h00000048);
		wr(stp_pkg::IDX_CNTH, 8'hFF);
		wr(stp_pkg::IDX_CTRL, 8'h0C);
		cyc(5);
		rdr(stp_pkg::IDX_CNTH);
		check(rd >= 32'h55 && rd < 32'h70, 1'b1);
		rdr(stp_pkg::IDX_CTRL);
		check(rd[7:6], 2'h3);
		wr(stp_pkg::IDX_MASK, 8'h03);
		wr(stp_pkg::IDX_CTRL, 8'h28);
		rdr(stp_pkg::IDX_STAT);
		cyc(40);
		check(irq, 1'b1);
		wr(stp_pkg::IDX_CTRL, 8'h08);
		rdr(stp_pkg::IDX_STAT);
		cyc(40);
		check(irq, 1'b0);
		$display("test split mode done");
	endtask

	// Watchdog: the tests need under a thousand cycles.
	initial begin
		repeat (20000) @(posedge aclk);
		num_errors++;
		complete_run();
	end

	// Main sequence.
	initial begin
		aresetn = 1'b0;
		ext_osc = 1'b0;
		awaddr = 12'h000;
		araddr = 12'h000;
		awvalid = 1'b0;
		wvalid = 1'b0;
		// Response ready is held high for the whole run; it never drops before an answer is seen.
		bready = 1'b1;
		arvalid = 1'b0;
		rready = 1'b1;
		wdata = 32'h00000000;
		wstrb = 4'h0;
		num_errors = 0;
		checks = 0;
		cyc(4);
		aresetn <= 1'b1;
		cyc(1);
		t_regs();
		t_wide();
		t_src();
		t_split();
		complete_run();
	end
endmodule
`default_nettype wire
